// file: verilog/irm_pkg.sv
package irm_pkg;

   // Timing figures as printed, in nanoseconds
   localparam int SHUTDOWN_PULSE_MIN_NS = 30000;
   localparam int PROGRAM_SETUP_TIME_NS = 200;
   localparam int REMOTE_SELECT_PULSE_NS = 200;
   localparam int PROGRAM_PULSE_MAX_NS = 5000;
   localparam int SELECT_SETUP_TIME_NS = 50;
   localparam int SELECT_HOLD_TIME_NS = 50;
   localparam int CLK_PERIOD_NS = 5;

   // Least times round up, longest times round down
   localparam int SHUTDOWN_CYC = (SHUTDOWN_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETUP_CYC = (PROGRAM_SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int REMOTE_CYC = (REMOTE_SELECT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PULSE_MAX_CYC = PROGRAM_PULSE_MAX_NS / CLK_PERIOD_NS;
   localparam int SSETUP_CYC = (SELECT_SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_CYC = (SELECT_HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam int CNT_W = 16;

   // Requested modes
   typedef enum logic [1:0] {
      IRM_MODE_SIR = 2'h0,
      IRM_MODE_FIR = 2'h1,
      IRM_MODE_RC = 2'h2
   } irm_mode_e;

   // Sequencer states, one-hot
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_SETUP = 7'h02,
      ST_RCPULSE = 7'h04,
      ST_SELECT = 7'h08,
      ST_HOLD = 7'h10,
      ST_SHUT = 7'h20,
      ST_WAKE = 7'h40
   } irm_state_e;

   typedef struct packed {
      logic power_down_input;
      logic irda_transmit_input;
      logic remote_transmit_input;
   } irm_pins_s;

   typedef struct packed {
      irm_state_e st;
      logic [CNT_W-1:0] cnt;
      irm_mode_e target;
      irm_mode_e mode;
      irm_pins_s pins;
   } irm_reg_s;

endpackage

// file: verilog/irm_host.sv
`timescale 1ns/1ps
module irm_host #(
   parameter int SHUT_CYCLES = irm_pkg::SHUTDOWN_CYC
) (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic PROG_REQ,
   input wire irm_pkg::irm_mode_e PROG_MODE,
   input wire logic SHUT_REQ,
   input wire logic WAKE_REQ,
   input wire logic DIRECT_EN,
   input wire logic TX_IRDA,
   input wire logic TX_REMOTE,
   output logic BUSY,
   output logic IN_SHUTDOWN,
   output irm_pkg::irm_mode_e MODE,
   output logic POWER_DOWN_INPUT,
   output logic IRDA_TRANSMIT_INPUT,
   output logic REMOTE_TRANSMIT_INPUT
);

   // How the sequencer drives the transceiver
   //
   // The host owns three pins of the transceiver: power-down, the IrDA transmit
   // input and the remote transmit input. All three leave flip-flops, so the
   // transceiver never sees a glitch from the decode below.
   //
   // In idle the pins follow the user's data. With DIRECT_EN low the block is
   // in single-input programmable mode: the IrDA transmit input carries data and
   // the remote transmit input stays low. With DIRECT_EN high both inputs pass
   // through, and a request for both LEDs at once is turned into idle, since the
   // transceiver would switch both transmitters off anyway.
   //
   // A programming request raises power-down with the transmit input low, waits
   // the setup time, then either sets the transmit input to the bandwidth level
   // or, for remote control, gives it a pulse of the remote select width. After
   // the select setup time power-down falls; that edge is where the transceiver
   // latches its mode. The transmit level is then held for the hold time before
   // the pins go back to data and BUSY drops.
   //
   // Every wait is a count of whole clock cycles rounded up from the least time,
   // so a slower count only stretches the sequence. The longest programming
   // pulse, setup plus remote pulse plus select setup, must stay well under the
   // programming pulse limit and far from the shutdown width; at the nominal
   // clock it is 90 cycles against a limit of 1000.
   //
   // A shutdown request raises power-down and keeps it up. Once the shutdown
   // width has passed the transceiver is back in SIR whatever it was before, and
   // MODE says so. WAKE_REQ is honoured only after that point, so a wake that
   // comes too early cannot turn a shutdown into a short programming pulse with
   // an unknown transmit level.
   //
   // PROG_REQ and SHUT_REQ that arrive while BUSY is high are dropped without notice; the
   // user must wait for BUSY to fall. SHUT_REQ wins over PROG_REQ in one cycle.
   //
   // MODE changes only at the end of a programming sequence or once the shutdown
   // width has passed, so a user that reads it while BUSY is low always sees the mode the transceiver holds.
   //
   // Limits: the block does not know whether the transceiver was powered while
   // reset was asserted. It assumes power-up and reset coincide, as both leave
   // the transceiver in SIR.
   //
   // Data on TX_IRDA and TX_REMOTE reaches the pins one cycle late, because the
   // pins are registered. Data given while BUSY is high is not passed on: the
   // programming sequence owns the transmit input until it returns to idle.
   // A user that streams data must therefore check BUSY before each request,
   // or the bits that fall into the sequence are lost.

   irm_pkg::irm_reg_s r_q;
   irm_pkg::irm_reg_s r_d;

   // Count target compare, cycles already spent in a state
   function automatic logic done(input logic [irm_pkg::CNT_W-1:0] c, input int n);
      done = (c >= irm_pkg::CNT_W'(n - 1));
   endfunction

   // Sequencer and pin drive
   always_comb begin
      r_d = r_q;
      r_d.cnt = r_q.cnt + irm_pkg::CNT_W'(1);
      case (r_q.st)
         // Idle: pins carry user data; requests start a sequence
         // Shutdown is checked first so that it wins over programming
         irm_pkg::ST_IDLE: begin
            r_d.cnt = '0;
            r_d.pins.power_down_input = 1'b0;
            // direct drive; transmit input carries data when idle
            if (DIRECT_EN) begin
               r_d.pins.irda_transmit_input = TX_IRDA & ~TX_REMOTE;
               r_d.pins.remote_transmit_input = TX_REMOTE & ~TX_IRDA;
            end else begin
               r_d.pins.irda_transmit_input = TX_IRDA;
               r_d.pins.remote_transmit_input = 1'b0;
            end
            if (SHUT_REQ) begin
               r_d.st = irm_pkg::ST_SHUT;
               r_d.pins.power_down_input = 1'b1;
               r_d.pins.irda_transmit_input = 1'b0;
               r_d.pins.remote_transmit_input = 1'b0;
            end else if (PROG_REQ) begin
               r_d.st = irm_pkg::ST_SETUP;
               r_d.target = PROG_MODE;
               r_d.pins.power_down_input = 1'b1;
               r_d.pins.irda_transmit_input = 1'b0;
               r_d.pins.remote_transmit_input = 1'b0;
            end
         end

         // Setup: power-down is high, transmit input held low
         // At the end the transmit input takes the selection level
         irm_pkg::ST_SETUP: begin
            if (done(r_q.cnt, irm_pkg::SETUP_CYC)) begin
               r_d.cnt = '0;
               if (r_q.target == irm_pkg::IRM_MODE_RC) begin
                  r_d.st = irm_pkg::ST_RCPULSE;
                  r_d.pins.irda_transmit_input = 1'b1;
               end else begin
                  r_d.st = irm_pkg::ST_SELECT;
                  r_d.pins.irda_transmit_input = (r_q.target == irm_pkg::IRM_MODE_FIR);
               end
            end
         end

         // Remote select pulse on the transmit input
         // It ends before the select setup so the latched level is low
         irm_pkg::ST_RCPULSE: begin
            if (done(r_q.cnt, irm_pkg::REMOTE_CYC)) begin
               r_d.cnt = '0;
               r_d.st = irm_pkg::ST_SELECT;
               r_d.pins.irda_transmit_input = 1'b0;
            end
         end

         // Select setup: level stands before power-down falls
         // The fall of power-down at the end latches the mode
         irm_pkg::ST_SELECT: begin
            if (done(r_q.cnt, irm_pkg::SSETUP_CYC)) begin
               r_d.cnt = '0;
               r_d.st = irm_pkg::ST_HOLD;
               r_d.pins.power_down_input = 1'b0;
            end
         end

         // Hold: level kept after the latching edge
         // MODE is updated here, when the transceiver holds it
         irm_pkg::ST_HOLD: begin
            if (done(r_q.cnt, irm_pkg::HOLD_CYC)) begin
               r_d.cnt = '0;
               r_d.st = irm_pkg::ST_IDLE;
               r_d.mode = r_q.target;
               r_d.pins.irda_transmit_input = 1'b0;
            end
         end

         // Shutdown: power-down stays high until a wake is taken
         // Wake is refused until the minimum width has passed
         irm_pkg::ST_SHUT: begin
            // Saturate the count once the minimum width has passed
            if (done(r_q.cnt, SHUT_CYCLES)) begin
               r_d.cnt = r_q.cnt;
               r_d.mode = irm_pkg::IRM_MODE_SIR;
               if (WAKE_REQ) begin
                  r_d.cnt = '0;
                  r_d.st = irm_pkg::ST_WAKE;
                  r_d.pins.power_down_input = 1'b0;
               end
            end
         end

         // Wake: power-down is low again; wait before new requests
         // The hold count keeps the edge clear of the next request
         irm_pkg::ST_WAKE: begin
            if (done(r_q.cnt, irm_pkg::HOLD_CYC)) begin
               r_d.cnt = '0;
               r_d.st = irm_pkg::ST_IDLE;
            end
         end

         // Unknown code: back to idle, pins keep their levels
         default: begin
            r_d.st = irm_pkg::ST_IDLE;
            r_d.cnt = '0;
         end
      endcase
   end

   // State register; starts in SIR with pins low
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         r_q.st <= irm_pkg::ST_IDLE;
         r_q.cnt <= '0;
         r_q.target <= irm_pkg::IRM_MODE_SIR;
         r_q.mode <= irm_pkg::IRM_MODE_SIR;
         r_q.pins <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   // Status outputs
   assign BUSY = (r_q.st != irm_pkg::ST_IDLE);
   assign IN_SHUTDOWN = (r_q.st == irm_pkg::ST_SHUT);
   assign MODE = r_q.mode;

   // Transceiver pins, straight from flip-flops
   assign POWER_DOWN_INPUT = r_q.pins.power_down_input;
   assign IRDA_TRANSMIT_INPUT = r_q.pins.irda_transmit_input;
   assign REMOTE_TRANSMIT_INPUT = r_q.pins.remote_transmit_input;

endmodule

// file: bench/irm_dev.sv
`timescale 1ns/1ps
module irm_dev #(parameter int SHUT = 200) (
   input wire logic clk,
   input wire logic pd,
   input wire logic tx,
   output irm_pkg::irm_mode_e mode
);
   int hi = 0, txw = 0;
   // Power-up in SIR; a long pulse shuts down, the falling edge latches the mode
   initial mode = irm_pkg::IRM_MODE_SIR;
   always @(posedge clk) begin
      hi <= pd ? hi + 1 : 0;
      txw <= pd ? txw + tx : 0;
      if (hi >= SHUT) mode <= irm_pkg::IRM_MODE_SIR;
      else if (!pd && hi > 0) mode <=
         irm_pkg::irm_mode_e'(txw >= irm_pkg::REMOTE_CYC ? 2'h2 : {1'b0, tx});
   end
endmodule

// file: bench/irm_host_sva.sv
`timescale 1ns/1ps
module irm_host_chk (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic IN_SHUTDOWN,
   input wire logic POWER_DOWN_INPUT,
   input wire logic IRDA_TRANSMIT_INPUT,
   input wire logic REMOTE_TRANSMIT_INPUT
);
   // Pin aliases
   wire pd = POWER_DOWN_INPUT;
   wire tx = IRDA_TRANSMIT_INPUT;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESETN);
   sequence opn; $rose(pd) && !IN_SHUTDOWN; endsequence
   sequence cls; $fell(pd); endsequence
   pulse_min_a: assert property (opn |-> pd [*8]) else $error("short");
   pulse_max_a: assert property (opn |-> ##[1:999] !pd) else $error("long");
   sel_setup_a: assert property (opn |-> !tx [*8]) else $error("early");
   sel_stable_a: assert property (cls |-> tx == $past(tx, 10)) else $error("moved");
   sel_hold_a: assert property (cls |=> $stable(tx) [*8]) else $error("hold");
   rc_width_a: assert property ($rose(tx) && pd |-> tx [*8]) else $error("rc");
   shut_width_a: assert property ($rose(IN_SHUTDOWN) |-> pd [*8]) else $error("shut");
   remote_low_a: assert property (pd |-> !REMOTE_TRANSMIT_INPUT) else $error("remote");
endmodule
bind irm_host irm_host_chk i_chk (.CLK(CLK), .RESETN(RESETN), .IN_SHUTDOWN(IN_SHUTDOWN),
   .POWER_DOWN_INPUT(POWER_DOWN_INPUT), .IRDA_TRANSMIT_INPUT(IRDA_TRANSMIT_INPUT),
   .REMOTE_TRANSMIT_INPUT(REMOTE_TRANSMIT_INPUT));

// file: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic clk = 0, rst_n = 0, prog = 0, shut = 0, wake = 0, busy, insd, pd, tx, rc;
   logic dir = 0, txi = 0, txr = 0;
   irm_pkg::irm_mode_e pm = irm_pkg::IRM_MODE_SIR, mode, dm;
   int fails = 0, tests_run = 0;
   irm_host #(.SHUT_CYCLES(200)) i_dut (.CLK(clk), .RESETN(rst_n), .PROG_REQ(prog),
      .PROG_MODE(pm), .SHUT_REQ(shut), .WAKE_REQ(wake), .DIRECT_EN(dir), .TX_IRDA(txi),
      .TX_REMOTE(txr), .BUSY(busy), .IN_SHUTDOWN(insd), .MODE(mode),
      .POWER_DOWN_INPUT(pd), .IRDA_TRANSMIT_INPUT(tx), .REMOTE_TRANSMIT_INPUT(rc));
   irm_dev i_dev (.clk(clk), .pd(pd), .tx(tx), .mode(dm));
   // Clock
   initial forever #2.5 clk = ~clk;
   task automatic chk(input string s, input logic [3:0] e, input logic [3:0] g);
      tests_run++;
      fails += (g !== e);
      if (g !== e) $display("BAD %s expected %h seen %h", s, e, g);
   endtask
   task automatic conclude();
      $display("compares %0d fails %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic req(ref logic r);
      r = 1;
      @(negedge clk) r = 0;
      repeat (400) if (busy !== 1'b0) @(negedge clk);
   endtask
   task automatic t_prog(input logic [1:0] m);
      pm = irm_pkg::irm_mode_e'(m);
      req(prog);
      chk("mode", {m, m}, {mode, dm});
   endtask
   task automatic t_shut();
      req(shut);
      chk("shutdown", 4'h0, {mode, dm});
      chk("in shutdown", 4'h1, {3'h0, insd});
      req(wake);
      chk("awake", 4'h0, {3'h0, insd, busy});
   endtask
   task automatic t_pins(input logic d, input logic i, input logic r, input logic [3:0] e);
      dir = d;
      txi = i;
      txr = r;
      repeat (2) @(negedge clk);
      chk("pins", e, {2'h0, tx, rc});
   endtask
   // Reset, then the scenarios
   initial begin
      repeat (16) @(negedge clk);
      rst_n = 1;
      chk("power-up", 4'h0, {mode, dm});
      t_pins(1'b1, 1'b0, 1'b1, 4'h1);
      t_pins(1'b1, 1'b1, 1'b0, 4'h2);
      t_pins(1'b1, 1'b1, 1'b1, 4'h0);
      t_pins(1'b0, 1'b1, 1'b1, 4'h2);
      t_pins(1'b0, 1'b0, 1'b0, 4'h0);
      t_prog(2'h2);
      t_prog(2'h0);
      t_prog(2'h1);
      t_shut();
      conclude();
   end
   // Watchdog
   initial begin
      #20000 fails++;
      conclude();
   end
endmodule
